/* File: psl_pkg.sv */
// package: addresses, fields, codes and states of the program security lock
package psl_pkg;

  // register addresses
  localparam logic [7:0]  FLASH_CTRL_ADDR = 8'hb2;
  localparam logic [15:0] BURN_TRIG_ADDR  = 16'hffd1;
  localparam logic [15:0] FUSE_SETUP_ADDR = 16'hffd2;
  localparam logic [15:0] SEC_STAT_ADDR   = 16'hffd7;

  // flash_control fields
  localparam int FC_PWE_BIT    = 0;
  localparam int FC_MEEN_BIT   = 1;
  localparam int FC_SECURE_BIT = 6;

  // security_fuse_status fields
  localparam int SS_FUSE1_BIT   = 0;
  localparam int SS_FUSE0_BIT   = 1;
  localparam int SS_PIN_BIT     = 5;
  localparam int SS_PROG_EN_BIT = 7;

  // fuse burning codes
  localparam logic [7:0] SETUP_KEY = 8'h54;
  localparam logic [7:0] SEL_MODE0 = 8'h81;
  localparam logic [7:0] SEL_MODE1 = 8'h82;
  localparam logic [7:0] BURN_ARM  = 8'ha6;

  localparam logic [6:0] PAGE_ZERO = 7'h00;
  localparam logic [7:0] REG_RESET = 8'h00;

  typedef enum logic [2:0] {
    EMU_RD_FLASH,
    EMU_WR_FLASH,
    EMU_PAGE_ERASE,
    EMU_MASS_ERASE,
    EMU_RD_XRAM,
    EMU_WR_XRAM,
    EMU_CTRL
  } psl_emu_op_e;

  typedef enum logic [1:0] {
    BURN_IDLE,
    BURN_KEYED,
    BURN_SELECTED,
    BURN_ON
  } psl_burn_e;

endpackage

/* File: psl_sec_if.sv */
// interface: security flags shared between the lock core and its access gate
`timescale 1ns/1ps
interface psl_sec_if;
  logic secure;
  logic mode0_act;
  logic mode1_act;
  logic erase_busy;
  modport core (output secure, output mode0_act, output mode1_act, output erase_busy);
  modport gate (input secure, input mode0_act, input mode1_act, input erase_busy);
endinterface

/* File: psl_fuse_burner.sv */
// fuse burn sequencer: key, fuse select, then arm or stop
`timescale 1ns/1ps
module psl_fuse_burner
  import psl_pkg::*;
(
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       resetn_in,
  // register writes
  input  wire logic       setup_wr_in,
  input  wire logic       trig_wr_in,
  input  wire logic [7:0] wdata_in,
  // qualifiers
  input  wire logic       prog_en_in,
  input  wire logic       sec_pin_in,
  // fuse drive
  output logic            burn_en_out,
  output logic [1:0]      burn_sel_out
);

  typedef struct packed {
    psl_burn_e  state;
    logic [1:0] sel;
  } psl_burn_s;

  psl_burn_s st_reg;
  psl_burn_s st_next;

  always_comb begin
    st_next = st_reg;
    unique case (st_reg.state)
      BURN_IDLE: begin
        if (setup_wr_in && wdata_in == SETUP_KEY) begin
          st_next.state = BURN_KEYED;
        end
      end
      BURN_KEYED: begin
        if (setup_wr_in) begin
          st_next.state = BURN_IDLE;
          // one fuse at a time; any other select drops the key
          if (wdata_in == SEL_MODE0 || wdata_in == SEL_MODE1) begin
            st_next.state = BURN_SELECTED;
            st_next.sel   = wdata_in[1:0];
          end
        end
      end
      BURN_SELECTED, BURN_ON: begin
        if (trig_wr_in) begin
          st_next.state = (wdata_in == BURN_ARM && prog_en_in) ? BURN_ON : BURN_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      st_reg <= '{state: BURN_IDLE, sel: 2'h0};
    end else begin
      st_reg <= st_next;
    end
  end

  // mode-1 fuse only takes current with the security pin high
  assign burn_en_out  = (st_reg.state == BURN_ON) && (st_reg.sel[0] || sec_pin_in);
  assign burn_sel_out = (st_reg.state == BURN_ON) ? st_reg.sel : 2'h0;

endmodule

/* File: psl_access_gate.sv */
// access gate: grants or refuses emulation and processor flash operations
`timescale 1ns/1ps
module psl_access_gate
  import psl_pkg::*;
(
  // security flags
  psl_sec_if.gate         sec,
  // emulation port request
  input  wire logic       emu_req_in,
  input  wire logic [2:0] emu_op_in,
  input  wire logic [6:0] emu_page_in,
  // processor flash request
  input  wire logic       cpu_page_erase_in,
  input  wire logic       cpu_flash_wr_in,
  input  wire logic [6:0] cpu_page_in,
  // answers
  output logic            emu_grant_out,
  output logic            emu_refuse_out,
  output logic            cpu_grant_out
);

  function automatic logic hits_page_zero(input logic [6:0] page, input logic secure);
    return secure && (page == PAGE_ZERO);
  endfunction

  psl_emu_op_e op;
  logic        emu_ok;

  always_comb begin
    op     = psl_emu_op_e'(emu_op_in);
    emu_ok = 1'b1;
    if (sec.mode1_act) begin
      emu_ok = 1'b0;
    end else if (sec.mode0_act && op != EMU_MASS_ERASE) begin
      emu_ok = 1'b0;
    end else if (sec.secure && (op == EMU_RD_FLASH || op == EMU_RD_XRAM)) begin
      emu_ok = 1'b0;
    end else if ((op == EMU_PAGE_ERASE || op == EMU_WR_FLASH) && hits_page_zero(emu_page_in, sec.secure)) begin
      emu_ok = 1'b0;
    end else if ((op == EMU_WR_FLASH || op == EMU_PAGE_ERASE || op == EMU_MASS_ERASE) && sec.erase_busy) begin
      emu_ok = 1'b0;
    end
    emu_grant_out  = emu_req_in && emu_ok;
    emu_refuse_out = emu_req_in && !emu_ok;
  end

  assign cpu_grant_out = (cpu_page_erase_in || cpu_flash_wr_in) && !sec.erase_busy
                         && !hits_page_zero(cpu_page_in, sec.secure);

endmodule

/* File: psl_lock_top.sv */
// program security lock: lock bit, fuse flags, burn control and port gating
//
// How it works
// - two security levels, each needs its own blown fuse
// - processor sets lock bit 6 of flash_control to enter mode 0
// - mode 0 lets the emulation port do bulk erase only
// - lock bit clears on reset; software may set, never clear it
// - mode 0 ends on any reset, erase or not, since reset clears the lock bit
// - global erase also clears all external data RAM
// - lock bit set blocks external reads of flash and data RAM
// - lock bit gives mode 0 only if mode-0 fuse is blown
// - blown fuse is permanent; nothing overrides it
// - lock bit set refuses page erase of page zero from anyone
// - lock bit set suppresses writes to page zero from anyone
// - mode-1 fuse blown disables emulation port for good
// - mode-1 fuse sampled during reset, before boot starts
// - emulation port disabled as soon as mode-1 fuse blows
// - security pin level reads live at status bit 5
// - mode-0 fuse burns whatever the security pin level
// - flash accepts programming again once bulk erase completes; lock bit and page-zero guard stay until reset
// - trigger starts burn only on arm value, else stops it
// - status bit 7 enables fuse programming
// - mass erase starts only while emulation port is enabled
`timescale 1ns/1ps
module psl_lock_top
  import psl_pkg::*;
(
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        resetn_in,

  // internal register port of the processor
  input  wire logic [7:0]  sfr_addr_in,
  input  wire logic        sfr_wr_in,
  input  wire logic        sfr_rd_in,
  input  wire logic [7:0]  sfr_wdata_in,
  output logic [7:0]       sfr_rdata_out,

  // external data mapped register port
  input  wire logic [15:0] xsfr_addr_in,
  input  wire logic        xsfr_wr_in,
  input  wire logic        xsfr_rd_in,
  input  wire logic [7:0]  xsfr_wdata_in,
  output logic [7:0]       xsfr_rdata_out,

  // processor state
  input  wire logic        int_enabled_in,

  // fuse sense and drive
  input  wire logic        mode0_fuse_in,
  input  wire logic        mode1_fuse_in,
  input  wire logic        sec_pin_in,
  output logic             burn_en_out,
  output logic [1:0]       burn_sel_out,

  // emulation port requests
  input  wire logic        emu_req_in,
  input  wire logic [2:0]  emu_op_in,
  input  wire logic [6:0]  emu_page_in,
  output logic             emu_grant_out,
  output logic             emu_refuse_out,
  output logic             emu_enabled_out,

  // processor flash requests
  input  wire logic        cpu_page_erase_in,
  input  wire logic        cpu_flash_wr_in,
  input  wire logic [6:0]  cpu_page_in,
  input  wire logic        cpu_mass_erase_in,
  output logic             cpu_grant_out,

  // flash controller
  output logic             mass_erase_go_out,
  output logic             xram_clear_out,
  input  wire logic        mass_erase_done_in,

  // security status
  output logic             ext_read_block_out,
  output logic             mode0_active_out,
  output logic             mode1_active_out,
  output logic             flash_pwe_out
);

  ////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic       secure;
    logic       pwe;
    logic       meen;
    logic       prog_en;
    logic       fuse0;
    logic       fuse1;
    logic       busy;
    logic       erase_go;
    logic [7:0] sfr_rdata;
    logic [7:0] xsfr_rdata;
  } psl_lock_s;

  psl_lock_s st_reg;
  psl_lock_s st_next;

  ////////////////////////////////////////////////////////////////////
  // decode

  logic fc_wr;
  logic fc_rd;
  logic ss_wr;
  logic ss_rd;
  logic setup_wr;
  logic trig_wr;

  assign fc_wr    = sfr_wr_in && (sfr_addr_in == FLASH_CTRL_ADDR);
  assign fc_rd    = sfr_rd_in && (sfr_addr_in == FLASH_CTRL_ADDR);
  assign ss_wr    = xsfr_wr_in && (xsfr_addr_in == SEC_STAT_ADDR);
  assign ss_rd    = xsfr_rd_in && (xsfr_addr_in == SEC_STAT_ADDR);
  assign setup_wr = xsfr_wr_in && (xsfr_addr_in == FUSE_SETUP_ADDR);
  assign trig_wr  = xsfr_wr_in && (xsfr_addr_in == BURN_TRIG_ADDR);

  ////////////////////////////////////////////////////////////////////
  // security flags

  logic emu_enabled;
  logic mode0_act;
  logic mass_start;

  // emulation port is dead the moment the mode-1 fuse reads blown
  assign emu_enabled = !(st_reg.fuse1 || mode1_fuse_in);

  // the lock bit alone is not enough; the fuse must already be blown
  assign mode0_act = st_reg.secure && st_reg.fuse0;

  psl_sec_if sec_if ();

  assign sec_if.secure     = st_reg.secure;
  assign sec_if.mode0_act  = mode0_act;
  assign sec_if.mode1_act  = !emu_enabled;
  assign sec_if.erase_busy = st_reg.busy;

  ////////////////////////////////////////////////////////////////////
  // access gate

  logic emu_grant;
  logic emu_mass;

  psl_access_gate u_gate (
    .sec               (sec_if.gate),
    .emu_req_in        (emu_req_in),
    .emu_op_in         (emu_op_in),
    .emu_page_in       (emu_page_in),
    .cpu_page_erase_in (cpu_page_erase_in),
    .cpu_flash_wr_in   (cpu_flash_wr_in),
    .cpu_page_in       (cpu_page_in),
    .emu_grant_out     (emu_grant),
    .emu_refuse_out    (emu_refuse_out),
    .cpu_grant_out     (cpu_grant_out)
  );

  assign emu_mass = emu_grant && (emu_op_in == EMU_MASS_ERASE);

  // processor mass erase needs the enable bit and a live emulation port
  assign mass_start = !st_reg.busy && emu_enabled
                      && ((cpu_mass_erase_in && st_reg.meen) || emu_mass);

  ////////////////////////////////////////////////////////////////////
  // fuse burner

  psl_fuse_burner u_burn (
    .clk_in       (clk_in),
    .resetn_in    (resetn_in),
    .setup_wr_in  (setup_wr),
    .trig_wr_in   (trig_wr),
    .wdata_in     (xsfr_wdata_in),
    .prog_en_in   (st_reg.prog_en),
    .sec_pin_in   (sec_pin_in),
    .burn_en_out  (burn_en_out),
    .burn_sel_out (burn_sel_out)
  );

  ////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    st_next          = st_reg;
    st_next.erase_go = 1'b0;

    // lock bit: writes of one stick, writes of zero are ignored
    if (fc_wr && sfr_wdata_in[FC_SECURE_BIT]) begin
      st_next.secure = 1'b1;
    end

    // write enable is locked while interrupts are on
    if (fc_wr && !int_enabled_in) begin
      st_next.pwe = sfr_wdata_in[FC_PWE_BIT];
    end
    if (cpu_flash_wr_in && cpu_grant_out) begin
      st_next.pwe = 1'b0;
    end

    if (fc_wr) begin
      st_next.meen = sfr_wdata_in[FC_MEEN_BIT];
    end

    if (ss_wr) begin
      st_next.prog_en = xsfr_wdata_in[SS_PROG_EN_BIT];
    end

    // fuse flags only ever set; no register path clears them
    st_next.fuse0 = st_reg.fuse0 || mode0_fuse_in;
    st_next.fuse1 = st_reg.fuse1 || mode1_fuse_in;

    // erase: start pulse, busy until the flash controller reports done
    if (mass_start) begin
      st_next.erase_go = 1'b1;
      st_next.busy     = 1'b1;
      st_next.meen     = 1'b0;
    end else if (mass_erase_done_in) begin
      st_next.busy = 1'b0;
    end

    if (fc_rd) begin
      st_next.sfr_rdata                = REG_RESET;
      st_next.sfr_rdata[FC_PWE_BIT]    = st_reg.pwe;
      st_next.sfr_rdata[FC_SECURE_BIT] = st_reg.secure;
    end

    // status read: program enable is write-only, pin level is live
    if (ss_rd) begin
      st_next.xsfr_rdata               = REG_RESET;
      st_next.xsfr_rdata[SS_FUSE0_BIT] = st_reg.fuse0;
      st_next.xsfr_rdata[SS_FUSE1_BIT] = st_reg.fuse1;
      st_next.xsfr_rdata[SS_PIN_BIT]   = sec_pin_in;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // registers

  // reset is synchronous, so sampling the fuse sense lines here is a
  // clocked capture while reset is held, ahead of any boot activity
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      st_reg.secure     <= 1'b0;
      st_reg.pwe        <= 1'b0;
      st_reg.meen       <= 1'b0;
      st_reg.prog_en    <= 1'b0;
      st_reg.fuse0      <= mode0_fuse_in;
      st_reg.fuse1      <= mode1_fuse_in;
      st_reg.busy       <= 1'b0;
      st_reg.erase_go   <= 1'b0;
      st_reg.sfr_rdata  <= REG_RESET;
      st_reg.xsfr_rdata <= REG_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outputs

  assign sfr_rdata_out      = st_reg.sfr_rdata;
  assign xsfr_rdata_out     = st_reg.xsfr_rdata;

  // erase and data RAM clear go together, lock bit or not
  assign mass_erase_go_out  = st_reg.erase_go;
  assign xram_clear_out     = st_reg.erase_go;

  assign ext_read_block_out = st_reg.secure;
  assign mode0_active_out   = mode0_act;
  assign mode1_active_out   = !emu_enabled;
  assign emu_enabled_out    = emu_enabled;
  assign emu_grant_out      = emu_grant;
  assign flash_pwe_out      = st_reg.pwe;

endmodule

/* File: psl_lock_assertions.sv */
// checker: port-level properties of the program security lock
`timescale 1ns/1ps
module psl_lock_assertions
  import psl_pkg::*;
(
  // clock and reset
  input logic        clk_in,
  input logic        resetn_in,
  // register ports
  input logic [7:0]  sfr_addr_in,
  input logic        sfr_wr_in,
  input logic [7:0]  sfr_wdata_in,
  input logic [15:0] xsfr_addr_in,
  input logic        xsfr_wr_in,
  input logic        xsfr_rd_in,
  input logic [7:0]  xsfr_wdata_in,
  input logic [7:0]  xsfr_rdata_out,
  // fuses, pin and ports
  input logic        mode1_fuse_in,
  input logic        sec_pin_in,
  input logic        burn_en_out,
  input logic        emu_req_in,
  input logic [2:0]  emu_op_in,
  input logic        emu_grant_out,
  input logic        emu_refuse_out,
  input logic        emu_enabled_out,
  input logic        cpu_page_erase_in,
  input logic        cpu_flash_wr_in,
  input logic [6:0]  cpu_page_in,
  input logic        cpu_grant_out,
  input logic        mass_erase_go_out,
  input logic        xram_clear_out,
  input logic        ext_read_block_out,
  input logic        mode0_active_out,
  input logic        mode1_active_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  sequence s_lock_wr;
    sfr_wr_in && sfr_addr_in == FLASH_CTRL_ADDR && sfr_wdata_in[FC_SECURE_BIT];
  endsequence
  sequence s_burn_stop;
    xsfr_wr_in && xsfr_addr_in == BURN_TRIG_ADDR && xsfr_wdata_in != BURN_ARM;
  endsequence

  ////////////////////////////////////////////////////////////////////////////////
  a_lock_sets: assert property (s_lock_wr |=> ext_read_block_out)
    else $error("lock bit did not set");
  a_lock_holds: assert property (ext_read_block_out |=> ext_read_block_out)
    else $error("lock bit cleared without reset");
  a_mode0_needs_lock: assert property (mode0_active_out |-> ext_read_block_out)
    else $error("mode 0 active without lock bit");
  a_mode0_erase_only: assert property (emu_req_in && mode0_active_out && emu_op_in != EMU_MASS_ERASE |-> emu_refuse_out && !emu_grant_out)
    else $error("emulation op granted in mode 0");
  a_mode1_refuse: assert property (emu_req_in && mode1_active_out |-> emu_refuse_out && !emu_grant_out)
    else $error("emulation op granted in mode 1");
  a_fuse_kills_port: assert property (mode1_fuse_in |-> !emu_enabled_out)
    else $error("port enabled with mode-1 fuse blown");
  a_page_zero_guard: assert property (ext_read_block_out && (cpu_flash_wr_in || cpu_page_erase_in) && cpu_page_in == PAGE_ZERO |-> !cpu_grant_out)
    else $error("page zero change granted under lock");
  a_erase_clears_xram: assert property (mass_erase_go_out |-> xram_clear_out && $past(emu_enabled_out))
    else $error("mass erase without xram clear or port");
  a_burn_stops: assert property (s_burn_stop |=> !burn_en_out)
    else $error("burn kept on after stop value");
  a_pin_live: assert property (xsfr_rd_in && xsfr_addr_in == SEC_STAT_ADDR |=> xsfr_rdata_out[SS_PIN_BIT] == $past(sec_pin_in))
    else $error("status pin bit not live");
endmodule

bind psl_lock_top psl_lock_assertions u_chk (
  .clk_in(clk_in), .resetn_in(resetn_in), .sfr_addr_in(sfr_addr_in), .sfr_wr_in(sfr_wr_in),
  .sfr_wdata_in(sfr_wdata_in), .xsfr_addr_in(xsfr_addr_in), .xsfr_wr_in(xsfr_wr_in), .xsfr_rd_in(xsfr_rd_in),
  .xsfr_wdata_in(xsfr_wdata_in), .xsfr_rdata_out(xsfr_rdata_out), .mode1_fuse_in(mode1_fuse_in),
  .sec_pin_in(sec_pin_in), .burn_en_out(burn_en_out), .emu_req_in(emu_req_in), .emu_op_in(emu_op_in),
  .emu_grant_out(emu_grant_out), .emu_refuse_out(emu_refuse_out), .emu_enabled_out(emu_enabled_out),
  .cpu_page_erase_in(cpu_page_erase_in), .cpu_flash_wr_in(cpu_flash_wr_in), .cpu_page_in(cpu_page_in),
  .cpu_grant_out(cpu_grant_out), .mass_erase_go_out(mass_erase_go_out), .xram_clear_out(xram_clear_out),
  .ext_read_block_out(ext_read_block_out), .mode0_active_out(mode0_active_out),
  .mode1_active_out(mode1_active_out));

/* File: psl_emu_host.sv */
// partner model: emulation debug host and the board's security pin
`timescale 1ns/1ps
module psl_emu_host (
  // clock and answer
  input  logic       clk_in,
  input  logic       emu_grant_in,
  // requests and board pin
  output logic       emu_req_out,
  output logic [2:0] emu_op_out,
  output logic [6:0] emu_page_out,
  output logic       sec_pin_out
);
  initial begin
    emu_req_out = 1'b0;
    emu_op_out = 3'h7;
    emu_page_out = 7'h7f;
    sec_pin_out = 1'b0;
  end

  task automatic issue(input logic [2:0] op, input logic [6:0] pg, output logic g);
    @(negedge clk_in);
    emu_req_out = 1'b1;
    emu_op_out = op;
    emu_page_out = pg;
    @(posedge clk_in);
    g = emu_grant_in;
    @(negedge clk_in);
    emu_req_out = 1'b0;
    // released fields flip so a stale value never looks like a request
    emu_op_out = ~op;
    emu_page_out = ~pg;
  endtask

  task automatic pin(input logic v);
    @(negedge clk_in);
    sec_pin_out = v;
  endtask
endmodule

/* File: tb_top.sv */
// testbench: register and emulation sequences for the program security lock
`timescale 1ns/1ps
module tb_top;
  import psl_pkg::*;
  logic        clk_in = 1'b0, resetn_in = 1'b0;
  logic [7:0]  sfr_addr_in = 8'h00, sfr_wdata_in = 8'h00, sfr_rdata_out;
  logic [15:0] xsfr_addr_in = 16'h0000;
  logic [7:0]  xsfr_wdata_in = 8'h00, xsfr_rdata_out;
  logic        sfr_wr_in = 1'b0, sfr_rd_in = 1'b0, xsfr_wr_in = 1'b0, xsfr_rd_in = 1'b0;
  logic        int_enabled_in = 1'b0, cpu_mass_erase_in = 1'b0, mass_erase_done_in = 1'b0;
  logic        mode0_fuse_in = 1'b1, mode1_fuse_in = 1'b0, sec_pin_in;
  logic        cpu_page_erase_in = 1'b0, cpu_flash_wr_in = 1'b0;
  logic [6:0]  cpu_page_in = 7'h00, emu_page_in;
  logic [2:0]  emu_op_in;
  logic [1:0]  burn_sel_out;
  logic        emu_req_in, emu_grant_out, emu_refuse_out, emu_enabled_out, burn_en_out, cpu_grant_out;
  logic        mass_erase_go_out, xram_clear_out, ext_read_block_out, mode0_active_out;
  logic        mode1_active_out, flash_pwe_out, g;
  int          err_count = 0, check_count = 0, i;

  always #4 clk_in = ~clk_in;

  psl_lock_top DUT (
    .clk_in(clk_in), .resetn_in(resetn_in), .sfr_addr_in(sfr_addr_in), .sfr_wr_in(sfr_wr_in),
    .sfr_rd_in(sfr_rd_in), .sfr_wdata_in(sfr_wdata_in), .sfr_rdata_out(sfr_rdata_out),
    .xsfr_addr_in(xsfr_addr_in), .xsfr_wr_in(xsfr_wr_in), .xsfr_rd_in(xsfr_rd_in),
    .xsfr_wdata_in(xsfr_wdata_in), .xsfr_rdata_out(xsfr_rdata_out), .int_enabled_in(int_enabled_in),
    .mode0_fuse_in(mode0_fuse_in), .mode1_fuse_in(mode1_fuse_in), .sec_pin_in(sec_pin_in),
    .burn_en_out(burn_en_out), .burn_sel_out(burn_sel_out), .emu_req_in(emu_req_in), .emu_op_in(emu_op_in),
    .emu_page_in(emu_page_in), .emu_grant_out(emu_grant_out), .emu_refuse_out(emu_refuse_out),
    .emu_enabled_out(emu_enabled_out), .cpu_page_erase_in(cpu_page_erase_in),
    .cpu_flash_wr_in(cpu_flash_wr_in), .cpu_page_in(cpu_page_in), .cpu_mass_erase_in(cpu_mass_erase_in),
    .cpu_grant_out(cpu_grant_out), .mass_erase_go_out(mass_erase_go_out), .xram_clear_out(xram_clear_out),
    .mass_erase_done_in(mass_erase_done_in), .ext_read_block_out(ext_read_block_out),
    .mode0_active_out(mode0_active_out), .mode1_active_out(mode1_active_out), .flash_pwe_out(flash_pwe_out));
  psl_emu_host host (.clk_in(clk_in), .emu_grant_in(emu_grant_out), .emu_req_out(emu_req_in),
                     .emu_op_out(emu_op_in), .emu_page_out(emu_page_in), .sec_pin_out(sec_pin_in));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic acc(input bit x, input bit wr, input logic [15:0] a, input logic [7:0] d);
    @(negedge clk_in);
    xsfr_addr_in = a;
    sfr_addr_in = a[7:0];
    xsfr_wdata_in = d;
    sfr_wdata_in = d;
    {xsfr_wr_in, xsfr_rd_in, sfr_wr_in, sfr_rd_in} = {x & wr, x & !wr, !x & wr, !x & !wr};
    @(negedge clk_in);
    {xsfr_wr_in, xsfr_rd_in, sfr_wr_in, sfr_rd_in} = 4'h0;
  endtask

  task automatic rd(input bit x, input logic [15:0] a, input logic [7:0] e);
    acc(x, 1'b0, a, 8'h00);
    chk(x ? xsfr_rdata_out : sfr_rdata_out, e);
  endtask

  task automatic cpu(input bit erase, input logic [6:0] p, input logic e);
    @(negedge clk_in);
    cpu_page_erase_in = erase;
    cpu_flash_wr_in = !erase;
    cpu_page_in = p;
    #1 chk({7'h00, cpu_grant_out}, {7'h00, e});
    @(negedge clk_in);
    {cpu_page_erase_in, cpu_flash_wr_in} = 2'b00;
  endtask

  task automatic rst();
    resetn_in = 1'b0;
    repeat (10) @(negedge clk_in);
    resetn_in = 1'b1;
  endtask

  // key, select, arm, look at the fuse drive, then stop the burn
  task automatic burn(input logic [7:0] sel, input logic [7:0] e);
    acc(1'b1, 1'b1, 16'hffd2, 8'h54);
    acc(1'b1, 1'b1, 16'hffd2, sel);
    acc(1'b1, 1'b1, 16'hffd1, 8'ha6);
    chk({5'h00, burn_en_out, burn_sel_out}, e);
    acc(1'b1, 1'b1, 16'hffd1, 8'h00);
    chk({7'h00, burn_en_out}, 8'h00);
  endtask

  task automatic summarize();
    $display("checks=%0d errors=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #200us;
    err_count++;
    summarize();
  end

  initial begin
    rst();
    rd(1'b0, 16'h00b2, 8'h00);
    rd(1'b1, 16'hffd7, 8'h02);
    host.pin(1'b1);
    rd(1'b1, 16'hffd7, 8'h22);
    cpu(1'b1, 7'h00, 1'b1);
    acc(1'b0, 1'b1, 16'h00b2, 8'h40);
    acc(1'b0, 1'b1, 16'h00b2, 8'h00);
    rd(1'b0, 16'h00b2, 8'h40);
    chk({6'h00, ext_read_block_out, mode0_active_out}, 8'h03);
    // mass erase last: it makes the flash busy for the rest
    for (i = 0; i < 7; i++) begin
      host.issue(3'((i + 4) % 7), 7'h01, g);
      chk({7'h00, g}, {7'h00, (i == 6)});
    end
    for (i = 0; i < 8 && mass_erase_go_out !== 1'b1; i++) @(negedge clk_in);
    if (i == 8)
      err_count++;
    chk({6'h00, mass_erase_go_out, xram_clear_out}, 8'h03);
    cpu(1'b0, 7'h05, 1'b0);
    mass_erase_done_in = 1'b1;
    @(negedge clk_in);
    mass_erase_done_in = 1'b0;
    // lock bit outlives the erase, so page zero stays shut until reset
    cpu(1'b0, 7'h00, 1'b0);
    cpu(1'b1, 7'h00, 1'b0);
    cpu(1'b1, 7'h05, 1'b1);
    acc(1'b0, 1'b1, 16'h00b2, 8'h41);
    chk({7'h00, flash_pwe_out}, 8'h01);
    cpu(1'b0, 7'h05, 1'b1);
    chk({7'h00, flash_pwe_out}, 8'h00);
    rst();
    rd(1'b0, 16'h00b2, 8'h00);
    host.issue(3'h0, 7'h01, g);
    chk({7'h00, g}, 8'h01);
    burn(8'h81, 8'h00);
    acc(1'b1, 1'b1, 16'hffd7, 8'h80);
    host.pin(1'b0);
    burn(8'h81, 8'h05);
    burn(8'h82, 8'h02);
    host.pin(1'b1);
    burn(8'h82, 8'h06);
    @(negedge clk_in);
    mode1_fuse_in = 1'b1;
    #1 chk({7'h00, emu_enabled_out}, 8'h00);
    host.issue(3'h3, 7'h01, g);
    chk({7'h00, g}, 8'h00);
    rst();
    // a sense line that drops after reset must not revive the port
    mode1_fuse_in = 1'b0;
    #1 chk({7'h00, mode1_active_out}, 8'h01);
    rd(1'b0, 16'h00b2, 8'h00);
    rd(1'b1, 16'hffd7, 8'h23);
    acc(1'b0, 1'b1, 16'h00b2, 8'h02);
    @(negedge clk_in);
    cpu_mass_erase_in = 1'b1;
    @(negedge clk_in);
    cpu_mass_erase_in = 1'b0;
    chk({7'h00, mass_erase_go_out}, 8'h00);
    summarize();
  end
endmodule
